// ===== rtl/brte_engine.sv
// Purpose: run-test self-test operations on the 36 I/O boundary cells
// Assumes: tap controller and instruction decode live outside, given as levels
// Notes: cells 17..0 face port A, 35..18 face port B; shadow mirrors that order
`timescale 1ns/1ps
module brte_engine (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// test access, from the tap side
	input wire logic tck,
	input wire logic tdi,
	input wire logic tap_capture_dr,
	input wire logic tap_shift_dr,
	input wire logic tap_run_idle,
	input wire logic run_test_instr,
	input wire logic [brte_pkg::OPC_W-1:0] test_control_reg,
	// output-enable cell contents, active low
	input wire logic byte1_a_to_b_enable_n,
	input wire logic byte2_a_to_b_enable_n,
	input wire logic byte1_b_to_a_enable_n,
	input wire logic byte2_b_to_a_enable_n,
	// seed scanned into the boundary chain
	input wire logic seed_load,
	input wire logic [brte_pkg::WORD-1:0] seed_value,
	// pins
	input wire logic [brte_pkg::CELLS-1:0] a_pin_in,
	input wire logic [brte_pkg::CELLS-1:0] b_pin_in,
	output logic [brte_pkg::CELLS-1:0] a_pin_out,
	output logic [1:0] a_pin_oe,
	output logic [brte_pkg::CELLS-1:0] b_pin_out,
	output logic [1:0] b_pin_oe,
	// scan out and status
	output logic tdo,
	output logic tdo_oe,
	output logic test_mode,
	output logic [brte_pkg::WORD-1:0] boundary_chain
);

	typedef struct packed {
		logic tck_q;
		brte_pkg::brte_op_type op_q;
		logic dir_ab_q;
		logic [brte_pkg::WORD-1:0] chain_q;
		logic [brte_pkg::WORD-1:0] shadow_q;
		logic bypass_q;
		logic tdo_q;
		logic tdo_oe_q;
		logic test_mode_q;
		logic [1:0] a_oe_q;
		logic [1:0] b_oe_q;
	} brte_state_type;

	brte_state_type st_q;
	brte_state_type st_d;

	// =====================================================================
	// synchronised inputs
	logic tck_s;
	logic tdi_s;
	logic cap_s;
	logic shift_s;
	logic idle_s;
	logic run_test_instr_s;
	logic [brte_pkg::OPC_W-1:0] opc_s;
	logic [brte_pkg::EN_W-1:0] en_s;
	logic [brte_pkg::CELLS-1:0] a_s;
	logic [brte_pkg::CELLS-1:0] b_s;
	logic seed_s;
	logic [brte_pkg::WORD-1:0] seedv_s;
	logic [brte_pkg::SYNC_W-1:0] sync_out;

	brte_sync #(
		.WIDTH(brte_pkg::SYNC_W)
	) u_sync (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.din({tck, tdi, tap_capture_dr, tap_shift_dr, tap_run_idle, run_test_instr, test_control_reg,
			byte1_a_to_b_enable_n, byte2_a_to_b_enable_n, byte1_b_to_a_enable_n, byte2_b_to_a_enable_n,
			a_pin_in, b_pin_in, seed_load, seed_value}),
		.dout(sync_out)
	);

	assign {tck_s, tdi_s, cap_s, shift_s, idle_s, run_test_instr_s, opc_s, en_s, a_s, b_s, seed_s, seedv_s} = sync_out;

	// =====================================================================
	// feedback functions
	function automatic logic [brte_pkg::WORD-1:0] lfsr36(input logic [brte_pkg::WORD-1:0] w);
		lfsr36 = {w[brte_pkg::WORD-2:0], w[brte_pkg::WORD-1] ^ w[brte_pkg::TAP36]};
	endfunction : lfsr36

	function automatic logic [brte_pkg::CELLS-1:0] lfsr18(input logic [brte_pkg::CELLS-1:0] w);
		lfsr18 = {w[brte_pkg::CELLS-2:0], w[brte_pkg::CELLS-1] ^ w[brte_pkg::TAP18]};
	endfunction : lfsr18

	// =====================================================================
	// edge detect and direction check
	logic rise;
	logic fall;
	logic dir_ok;
	logic dir_ab;
	logic [brte_pkg::CELLS-1:0] in_cells;
	logic [brte_pkg::CELLS-1:0] out_cells;
	logic [brte_pkg::CELLS-1:0] in_pins;
	logic [brte_pkg::CELLS-1:0] in_new;
	logic [brte_pkg::CELLS-1:0] out_new;
	logic [brte_pkg::WORD-1:0] word;
	logic [brte_pkg::WORD-1:0] word_new;
	logic e1ab;
	logic e2ab;
	logic e1ba;
	logic e2ba;

	assign rise = tck_s & ~st_q.tck_q;
	assign fall = ~tck_s & st_q.tck_q;
	assign {e1ab, e2ab, e1ba, e2ba} = en_s;
	assign dir_ok = (e1ab != e1ba) && (e2ab != e2ba) && (e1ab == e2ab) && (e1ba == e2ba);
	assign dir_ab = ~e1ab;

	// =====================================================================
	// next-state logic
	always_comb
	begin
		st_d = st_q;
		st_d.tck_q = tck_s;
		st_d.dir_ab_q = dir_ab;
		in_cells = st_q.dir_ab_q ? st_q.chain_q[brte_pkg::CELLS-1:0] : st_q.chain_q[brte_pkg::WORD-1:brte_pkg::CELLS];
		out_cells = st_q.dir_ab_q ? st_q.chain_q[brte_pkg::WORD-1:brte_pkg::CELLS] : st_q.chain_q[brte_pkg::CELLS-1:0];
		in_pins = st_q.dir_ab_q ? a_s : b_s;
		word = {out_cells, in_cells};
		word_new = word;
		in_new = in_cells;
		out_new = out_cells;

		// gate on instruction and idle state
		if (!run_test_instr_s || !idle_s || !dir_ok)
		begin
			st_d.op_q = brte_pkg::BRTE_OP_IDLE;
		end
		else
		begin
			unique case (opc_s[1:0])
				brte_pkg::OPC_TOGGLE: st_d.op_q = brte_pkg::BRTE_OP_TOGGLE;
				brte_pkg::OPC_PATTERN: st_d.op_q = brte_pkg::BRTE_OP_PATTERN;
				brte_pkg::OPC_SIGN: st_d.op_q = brte_pkg::BRTE_OP_SIGN;
				brte_pkg::OPC_COMBINED: st_d.op_q = opc_s[brte_pkg::OPC_HI] ? brte_pkg::BRTE_OP_SIGCNT
					: brte_pkg::BRTE_OP_SIGPAT;
			endcase
		end

		// order {out,in}, lsb at cell 0 of each half
		unique case (st_q.op_q)
			brte_pkg::BRTE_OP_IDLE:
			begin
				word_new = word;
			end
			brte_pkg::BRTE_OP_TOGGLE:
			begin
				in_new = in_pins;
				out_new = ~out_cells;
				word_new = {out_new, in_new};
			end
			brte_pkg::BRTE_OP_PATTERN:
			begin
				word_new = lfsr36(word);
			end
			brte_pkg::BRTE_OP_SIGN:
			begin
				// fold inputs into the 36-bit signature
				word_new = lfsr36(word) ^ {{brte_pkg::CELLS{1'b0}}, in_pins};
			end
			brte_pkg::BRTE_OP_SIGPAT:
			begin
				in_new = lfsr18(in_cells) ^ in_pins;
				out_new = lfsr18(out_cells);
				word_new = {out_new, in_new};
			end
			brte_pkg::BRTE_OP_SIGCNT:
			begin
				in_new = lfsr18(in_cells) ^ in_pins;
				out_new = out_cells + brte_pkg::COUNT_STEP;
				word_new = {out_new, in_new};
			end
		endcase

		// only the 36 i/o cells are held and changed here
		if (seed_s)
		begin
			st_d.chain_q = seedv_s;
			st_d.shadow_q = seedv_s;
		end
		else if (rise)
		begin
			// shift stages move on the rising edge
			st_d.chain_q = st_q.dir_ab_q ? {word_new[brte_pkg::WORD-1:brte_pkg::CELLS], word_new[brte_pkg::CELLS-1:0]}
				: {word_new[brte_pkg::CELLS-1:0], word_new[brte_pkg::WORD-1:brte_pkg::CELLS]};
		end
		else if (fall && st_q.op_q != brte_pkg::BRTE_OP_IDLE && st_q.op_q != brte_pkg::BRTE_OP_SIGN)
		begin
			if (st_q.dir_ab_q)
			begin
				st_d.shadow_q[brte_pkg::WORD-1:brte_pkg::CELLS] = st_q.chain_q[brte_pkg::WORD-1:brte_pkg::CELLS];
			end
			else
			begin
				st_d.shadow_q[brte_pkg::CELLS-1:0] = st_q.chain_q[brte_pkg::CELLS-1:0];
			end
		end

		if (rise && run_test_instr_s)
		begin
			if (cap_s)
			begin
				st_d.bypass_q = 1'b0;
			end
			else if (shift_s)
			begin
				st_d.bypass_q = tdi_s;
			end
		end
		// scan out moves on the falling edge
		if (fall)
		begin
			st_d.tdo_q = st_q.bypass_q;
			st_d.tdo_oe_q = shift_s;
		end

		st_d.test_mode_q = run_test_instr_s;
		// enable cells steer the output groups
		st_d.a_oe_q = run_test_instr_s ? {~e2ba, ~e1ba} : brte_pkg::OE_RESET;
		st_d.b_oe_q = run_test_instr_s ? {~e2ab, ~e1ab} : brte_pkg::OE_RESET;
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= '{tck_q: 1'b0, op_q: brte_pkg::BRTE_OP_IDLE, dir_ab_q: 1'b0,
				chain_q: brte_pkg::CHAIN_RESET, shadow_q: brte_pkg::CHAIN_RESET, bypass_q: 1'b0,
				tdo_q: 1'b0, tdo_oe_q: 1'b0, test_mode_q: 1'b0, a_oe_q: brte_pkg::OE_RESET,
				b_oe_q: brte_pkg::OE_RESET};
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// =====================================================================
	// outputs, one byte group per oe bit
	assign a_pin_out = st_q.shadow_q[brte_pkg::CELLS-1:0];
	assign b_pin_out = st_q.shadow_q[brte_pkg::WORD-1:brte_pkg::CELLS];
	assign a_pin_oe = st_q.a_oe_q;
	assign b_pin_oe = st_q.b_oe_q;
	assign tdo = st_q.tdo_q;
	assign tdo_oe = st_q.tdo_oe_q;
	assign test_mode = st_q.test_mode_q;
	assign boundary_chain = st_q.chain_q;

	// =====================================================================
	// checks
	logic step;
	logic ab_run;
	assign step = rise & ~seed_s;
	assign ab_run = st_q.dir_ab_q & step;

	property p_gate;
		@(posedge clk_sys) disable iff (!resetn)
		(!run_test_instr_s || !idle_s) |=> st_q.op_q == brte_pkg::BRTE_OP_IDLE;
	endproperty
	a_gate: assert property (p_gate) else $error("operation outside run-test idle");

	property p_bypass_dir;
		@(posedge clk_sys) disable iff (!resetn)
		!dir_ok |=> st_q.op_q == brte_pkg::BRTE_OP_IDLE;
	endproperty
	a_bypass_dir: assert property (p_bypass_dir) else $error("operation with mixed direction");

	property p_idle_hold;
		@(posedge clk_sys) disable iff (!resetn)
		(st_q.op_q == brte_pkg::BRTE_OP_IDLE && !seed_s) |=> $stable(st_q.chain_q);
	endproperty
	a_idle_hold: assert property (p_idle_hold) else $error("chain changed while idle");

	property p_sample;
		@(posedge clk_sys) disable iff (!resetn)
		(ab_run && st_q.op_q == brte_pkg::BRTE_OP_TOGGLE) |=> st_q.chain_q[brte_pkg::CELLS-1:0] == $past(a_s);
	endproperty
	a_sample: assert property (p_sample) else $error("input sample missed");

	property p_toggle;
		@(posedge clk_sys) disable iff (!resetn)
		(ab_run && st_q.op_q == brte_pkg::BRTE_OP_TOGGLE) |=>
			st_q.chain_q[brte_pkg::WORD-1:brte_pkg::CELLS] == ~$past(st_q.chain_q[brte_pkg::WORD-1:brte_pkg::CELLS]);
	endproperty
	a_toggle: assert property (p_toggle) else $error("output cells not inverted");

	property p_zero_seed;
		@(posedge clk_sys) disable iff (!resetn)
		(step && st_q.op_q == brte_pkg::BRTE_OP_PATTERN && st_q.chain_q == brte_pkg::CHAIN_RESET) |=>
			st_q.chain_q == brte_pkg::CHAIN_RESET;
	endproperty
	a_zero_seed: assert property (p_zero_seed) else $error("pattern escaped the all-zero seed");

	property p_sign_shadow;
		@(posedge clk_sys) disable iff (!resetn)
		(st_q.op_q == brte_pkg::BRTE_OP_SIGN && !seed_s) |=> $stable(st_q.shadow_q);
	endproperty
	a_sign_shadow: assert property (p_sign_shadow) else $error("shadow moved in signature mode");

	property p_count;
		@(posedge clk_sys) disable iff (!resetn)
		(ab_run && st_q.op_q == brte_pkg::BRTE_OP_SIGCNT) |=> st_q.chain_q[brte_pkg::WORD-1:brte_pkg::CELLS]
			== $past(st_q.chain_q[brte_pkg::WORD-1:brte_pkg::CELLS]) + brte_pkg::COUNT_STEP;
	endproperty
	a_count: assert property (p_count) else $error("count did not advance by one");

	property p_capture;
		@(posedge clk_sys) disable iff (!resetn)
		(rise && run_test_instr_s && cap_s) |=> !st_q.bypass_q;
	endproperty
	a_capture: assert property (p_capture) else $error("bypass did not capture zero");

	property p_tdo;
		@(posedge clk_sys) disable iff (!resetn)
		fall |=> st_q.tdo_q == $past(st_q.bypass_q) && st_q.tdo_oe_q == $past(shift_s);
	endproperty
	a_tdo: assert property (p_tdo) else $error("scan out not moved on falling edge");

	property p_oe;
		@(posedge clk_sys) disable iff (!resetn)
		(run_test_instr_s && !e1ab) |=> st_q.b_oe_q[0];
	endproperty
	a_oe: assert property (p_oe) else $error("output group not enabled");

	c_toggle: cover property (@(posedge clk_sys) disable iff (!resetn) step && st_q.op_q == brte_pkg::BRTE_OP_TOGGLE);
	c_pattern: cover property (@(posedge clk_sys) disable iff (!resetn) step && st_q.op_q == brte_pkg::BRTE_OP_PATTERN);
	c_sign: cover property (@(posedge clk_sys) disable iff (!resetn) step && st_q.op_q == brte_pkg::BRTE_OP_SIGN);
	c_count: cover property (@(posedge clk_sys) disable iff (!resetn) step && st_q.op_q == brte_pkg::BRTE_OP_SIGCNT);

endmodule : brte_engine

// ===== common/brte_pkg.sv
// Purpose: constants and types shared by the boundary run-test engine
// Assumes: one 125 MHz system clock samples the slow test clock and all pins
// Notes: control-input cells are not held here; only the 36 I/O cells take part
package brte_pkg;

	// =====================================================================
	// geometry
	localparam int unsigned CELLS = 18;
	localparam int unsigned WORD = 36;
	localparam int unsigned BYTE_W = 9;
	localparam int unsigned OPC_W = 3;
	localparam int unsigned EN_W = 4;

	// =====================================================================
	// opcode decode on the two low bits, bit 2 splits the combined modes
	localparam logic [1:0] OPC_TOGGLE = 2'h0;
	localparam logic [1:0] OPC_PATTERN = 2'h1;
	localparam logic [1:0] OPC_SIGN = 2'h2;
	localparam logic [1:0] OPC_COMBINED = 2'h3;
	localparam int unsigned OPC_HI = 2;

	// =====================================================================
	// feedback taps: x^36+x^25+1 and x^18+x^11+1, both maximal length
	localparam int unsigned TAP36 = 24;
	localparam int unsigned TAP18 = 10;
	localparam logic [CELLS-1:0] COUNT_STEP = 18'h00001;

	// =====================================================================
	// reset values
	localparam logic [WORD-1:0] CHAIN_RESET = 36'h000000000;
	localparam logic [1:0] OE_RESET = 2'h0;

	// =====================================================================
	// synchroniser width: tck tdi capture shift idle runtest opc en a b seed_load seed
	localparam int unsigned SYNC_W = 6 + OPC_W + EN_W + CELLS + CELLS + 1 + WORD;

	typedef enum logic [5:0] {
		BRTE_OP_IDLE = 6'h01,
		BRTE_OP_TOGGLE = 6'h02,
		BRTE_OP_PATTERN = 6'h04,
		BRTE_OP_SIGN = 6'h08,
		BRTE_OP_SIGPAT = 6'h10,
		BRTE_OP_SIGCNT = 6'h20
	} brte_op_type;

endpackage : brte_pkg

// ===== rtl/brte_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ps
module brte_sync #(
	parameter int unsigned WIDTH = 1
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);

	typedef struct packed {
		logic [WIDTH-1:0] s1_q;
		logic [WIDTH-1:0] s2_q;
		logic [WIDTH-1:0] s3_q;
		logic [WIDTH-1:0] agreed_q;
	} brte_sync_type;

	brte_sync_type st_q;
	brte_sync_type st_d;

	// =====================================================================
	// stage one feeds stage two only
	always_comb
	begin
		st_d = st_q;
		st_d.s1_q = din;
		st_d.s2_q = st_q.s1_q;
		st_d.s3_q = st_q.s2_q;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (st_q.s2_q[i] == st_q.s3_q[i])
			begin
				st_d.agreed_q[i] = st_q.s3_q[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign dout = st_q.agreed_q;

endmodule : brte_sync

// ===== tb/brte_tap_model.sv
// Purpose: test controller stand-in driving tap levels, tck and seed
// Assumes: levels move only while tck is low
// Notes: tck stands still low between frames
`timescale 1ns/1ps
module brte_tap_model (
	// clock
	input wire logic clk_sys,
	// tap side
	output logic tck,
	output logic tdi,
	output logic tap_capture_dr,
	output logic tap_shift_dr,
	output logic tap_run_idle,
	output logic run_test_instr,
	output logic [brte_pkg::OPC_W-1:0] test_control_reg,
	// enable cells {2ba,1ba,2ab,1ab}, active low
	output logic [brte_pkg::EN_W-1:0] en_n,
	// seed scan
	output logic seed_load,
	output logic [brte_pkg::WORD-1:0] seed_value
);
	initial
	begin
		{tck, tdi, tap_capture_dr, tap_shift_dr, tap_run_idle, run_test_instr, seed_load} = 7'h00;
		test_control_reg = 3'h0;
		en_n = 4'hC;
		seed_value = 36'h000000000;
	end

	// =====================================================================
	// levels
	// opcode before run-test
	task automatic setup(input logic [2:0] opc, input logic [3:0] en, input logic rt, input logic idle,
		input logic cap, input logic sh, input logic d);
		@(negedge clk_sys);
		test_control_reg = opc;
		en_n = en;
		repeat (2) @(negedge clk_sys);
		{run_test_instr, tap_run_idle, tap_capture_dr, tap_shift_dr, tdi} = {rt, idle, cap, sh, d};
		repeat (8) @(negedge clk_sys);
	endtask : setup

	// =====================================================================
	// seed
	// seed before running
	task automatic load_seed(input logic [35:0] s);
		@(negedge clk_sys);
		seed_value = s;
		seed_load = 1'b1;
		repeat (8) @(negedge clk_sys);
		seed_load = 1'b0;
		// stale seed must not leak through
		seed_value = ~s;
		repeat (8) @(negedge clk_sys);
	endtask : load_seed

	// =====================================================================
	// one tck frame, 80 ns low, 80 ns high, 80 ns low
	task automatic pulse();
		repeat (10) @(negedge clk_sys);
		tck = 1'b1;
		repeat (10) @(negedge clk_sys);
		tck = 1'b0;
		repeat (10) @(negedge clk_sys);
	endtask : pulse
endmodule : brte_tap_model

// ===== tb/brte_engine_test.sv
// Purpose: self-checking bench for the run-test engine
// Assumes: reference model steps once per tck frame
// Notes: pins and seeds come from an xorshift source
`timescale 1ns/1ps
module brte_engine_test;
	logic clk_sys = 1'b0;
	logic resetn = 1'b0;
	logic tck, tdi, tap_capture_dr, tap_shift_dr, tap_run_idle, run_test_instr, seed_load;
	logic [brte_pkg::OPC_W-1:0] test_control_reg;
	logic [brte_pkg::EN_W-1:0] en_n;
	logic [brte_pkg::WORD-1:0] seed_value, boundary_chain;
	logic [brte_pkg::CELLS-1:0] a_pin_in = '0, b_pin_in = '0, a_pin_out, b_pin_out;
	logic [1:0] a_pin_oe, b_pin_oe;
	logic tdo, tdo_oe, test_mode;
	logic [35:0] chain_m = '0, shad_m = '0;
	logic byp_m = 1'b0;
	logic [31:0] rnd = 32'h00013AA2;
	int err_total = 0;
	int n_tests = 0;

	always #4 clk_sys = ~clk_sys;

	brte_tap_model tap_u (.clk_sys, .tck, .tdi, .tap_capture_dr, .tap_shift_dr, .tap_run_idle,
		.run_test_instr, .test_control_reg, .en_n, .seed_load, .seed_value);

	brte_engine dut_u (.clk_sys, .resetn, .tck, .tdi, .tap_capture_dr, .tap_shift_dr, .tap_run_idle,
		.run_test_instr, .test_control_reg, .byte1_a_to_b_enable_n(en_n[0]),
		.byte2_a_to_b_enable_n(en_n[1]), .byte1_b_to_a_enable_n(en_n[2]), .byte2_b_to_a_enable_n(en_n[3]),
		.seed_load, .seed_value, .a_pin_in, .b_pin_in, .a_pin_out, .a_pin_oe, .b_pin_out, .b_pin_oe,
		.tdo, .tdo_oe, .test_mode, .boundary_chain);

	// =====================================================================
	// helpers
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs

	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic test_done();
		if (err_total == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : test_done

	// =====================================================================
	// reference model, one rise and fall
	task automatic step_model();
		logic ab;
		logic ok;
		logic [17:0] pin, ih, oh;
		logic [35:0] w;
		if (run_test_instr)
			byp_m = tap_capture_dr ? 1'b0 : (tap_shift_dr ? tdi : byp_m);
		ab = ~en_n[0];
		ok = (en_n[0] != en_n[2]) && (en_n[1] != en_n[3]) && (en_n[0] == en_n[1]) && (en_n[2] == en_n[3]);
		if (!(ok && run_test_instr && tap_run_idle))
			return;
		pin = ab ? a_pin_in : b_pin_in;
		ih = ab ? chain_m[17:0] : chain_m[35:18];
		oh = ab ? chain_m[35:18] : chain_m[17:0];
		w = {oh, ih};
		case (test_control_reg[1:0])
			2'h0: w = {~oh, pin};
			2'h1: w = {w[34:0], w[35] ^ w[24]};
			2'h2: w = {w[34:0], w[35] ^ w[24]} ^ {18'h00000, pin};
			default: w = {(test_control_reg[2] ? oh + 18'h00001 : {oh[16:0], oh[17] ^ oh[10]}),
				({ih[16:0], ih[17] ^ ih[10]} ^ pin)};
		endcase
		chain_m = ab ? w : {w[17:0], w[35:18]};
		// signature mode leaves the shadow alone
		if (test_control_reg[1:0] != 2'h2 && ab)
			shad_m[35:18] = chain_m[35:18];
		if (test_control_reg[1:0] != 2'h2 && !ab)
			shad_m[17:0] = chain_m[17:0];
	endtask : step_model

	task automatic run_cycle();
		@(negedge clk_sys);
		rnd = xs(rnd);
		a_pin_in = rnd[17:0];
		rnd = xs(rnd);
		b_pin_in = rnd[17:0];
		step_model();
		tap_u.pulse();
	endtask : run_cycle

	task automatic compare_all();
		check("chain", boundary_chain, chain_m);
		check("pins", {b_pin_out, a_pin_out}, shad_m);
		check("oe", {b_pin_oe, a_pin_oe}, run_test_instr ? {~en_n[1], ~en_n[0], ~en_n[3], ~en_n[2]} : 4'h0);
		check("mode", test_mode, run_test_instr);
		check("tdo", {tdo_oe, tdo}, {tap_shift_dr, byp_m});
	endtask : compare_all

	task automatic seed_run(input logic [2:0] opc, input logic [3:0] en, input logic [35:0] s);
		tap_u.setup(opc, en, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		tap_u.load_seed(s);
		chain_m = s;
		shad_m = s;
		compare_all();
		tap_u.setup(opc, en, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
	endtask : seed_run

	// =====================================================================
	// watchdog
	initial
	begin
		#500000;
		err_total++;
		test_done();
	end

	// =====================================================================
	// main sequence
	initial
	begin
		repeat (20) @(posedge clk_sys);
		@(negedge clk_sys);
		resetn = 1'b1;
		repeat (8) @(negedge clk_sys);
		compare_all();
		// every opcode in both directions
		for (int op = 0; op < 8; op++)
		begin
			for (int d = 0; d < 2; d++)
			begin
				rnd = xs(rnd);
				seed_run(op[2:0], d ? 4'h3 : 4'hC, {rnd[3:0], xs(rnd)});
				repeat (4)
				begin
					run_cycle();
					compare_all();
				end
				check("tail", boundary_chain, chain_m);
			end
		end
		// zero seed stays put
		seed_run(3'h1, 4'hC, 36'h000000000);
		run_cycle();
		compare_all();
		// refused: bad directions, idle low, run-test low
		foreach (en_n[i])
		begin
			seed_run(3'h0, 4'hC, {4'h5, xs(rnd)});
			tap_u.setup(3'h0, i[0] ? 4'h5 : 4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
			if (i > 1)
				tap_u.setup(3'h0, 4'hC, i[0], ~i[0], 1'b0, 1'b0, 1'b0);
			run_cycle();
			compare_all();
		end
		// bypass shift then capture
		tap_u.setup(3'h0, 4'hC, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
		run_cycle();
		compare_all();
		tap_u.setup(3'h0, 4'hC, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
		run_cycle();
		compare_all();
		test_done();
	end
endmodule : brte_engine_test
